// file: src/sps_pkg.sv
/*
  Shared constants of the synchronous serial port: register offsets, field
  positions, mode codes and clock divider figures.
  Assumes a 32-bit AHB-Lite register bus decoding the low address byte.
*/
package sps_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL1 = 8'h00;
  localparam logic [7:0] REG_CTRL2 = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_BUF = 8'h0C;
  localparam logic [7:0] REG_ADDR = 8'h10;
  localparam logic [7:0] REG_EVT = 8'h14;

  // Field positions
  localparam int unsigned C1_WRITE_COLLISION_FLAG = 7;
  localparam int unsigned C1_OVF = 6;
  localparam int unsigned C1_EN = 5;
  localparam int unsigned C1_CKP = 4;
  localparam int unsigned C2_STOP = 2;
  localparam int unsigned ST_CKE = 6;
  localparam int unsigned ST_BF = 0;
  localparam int unsigned EV_IF = 0;

  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;

  // Mode select codes
  localparam logic [3:0] M_SPI_M4 = 4'h0;
  localparam logic [3:0] M_SPI_M16 = 4'h1;
  localparam logic [3:0] M_SPI_M64 = 4'h2;
  localparam logic [3:0] M_SPI_MT = 4'h3;
  localparam logic [3:0] M_SPI_S_SS = 4'h4;
  localparam logic [3:0] M_SPI_S = 4'h5;
  localparam logic [3:0] M_TW_S7 = 4'h6;
  localparam logic [3:0] M_TW_S10 = 4'h7;
  localparam logic [3:0] M_TW_M = 4'h8;
  localparam logic [3:0] M_TW_FW = 4'hB;
  localparam logic [3:0] M_TW_S7_SP = 4'hE;
  localparam logic [3:0] M_TW_S10_SP = 4'hF;

  // Half periods of the master serial clock, in system clocks
  localparam logic [9:0] HALF_DIV4 = 10'h002;
  localparam logic [9:0] HALF_DIV16 = 10'h008;
  localparam logic [9:0] HALF_DIV64 = 10'h020;

endpackage

// file: src/sps_sync2.sv
/*
  Two-flop synchroniser for a group of asynchronous pin inputs.
  Assumes the inputs are quasi-static with respect to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module sps_sync2 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: src/sps_tick.sv
/*
  Programmable tick generator: one pulse every period_i clocks while run_i.
  Assumes period_i is stable while run_i is high and is at least one.
*/
`timescale 1ns/1ps
`default_nettype none
module sps_tick #(
  parameter int unsigned CNT_W = 10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic [CNT_W-1:0] period_i,
  output logic tick_o
);
  logic [CNT_W-1:0] cnt_q;
  logic last;

  initial
  begin
    if (CNT_W < 2) $error("sps_tick: CNT_W too small");
  end

  assign last = (cnt_q == (period_i - CNT_W'(1)));
  assign tick_o = run_i & last;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i || last)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + CNT_W'(1);
  end
endmodule
`default_nettype wire

// file: src/sps_core.sv
/*
  Synchronous serial port, SPI personality, with the mode-level bits of the
  two-wire mode, behind an AHB-Lite register slave.
  Assumes one clock clk_i, synchronous active-high reset, and external
  buffers that resolve the pin output enables onto the pads.
*/
// Chosen here: the register offsets and the AHB-Lite register port.
// Function
// - After eight bits, load the byte into the buffer, set full and interrupt flags
// - Shift register moves data most significant bit first
// - Buffer write during a transfer is dropped and sets write collision
// - Reading the buffer clears the buffer-full flag
// - New byte with buffer still full is discarded, and sets overflow in slave modes
// - Overflow can only be set in slave operation
// - Two-wire receive into a full buffer also sets overflow
// - Port enable hands the serial pins to the port, else releases them
// - SPI clock polarity bit sets the serial clock idle level
// - Two-wire slave: polarity bit zero stretches clock low, one releases
// - Mode codes select SPI master rates and slave without select
// - Code 1000 two-wire master, 1011 firmware master with slave idle
// - Reserved mode codes leave the port idle
// - Code 1111 two-wire slave with start and stop interrupts
// - Two-wire master buffer write on a busy bus sets write collision
// - Next byte may start before the previous one is read
// - Shift register is reached only through the buffer register
`timescale 1ns/1ps
`default_nettype none
module sps_core #(
  parameter int unsigned DATA_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Serial clock pin (SCK / SCL)
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  // Serial data out pin
  output logic sdo_o,
  output logic sdo_oe_o,
  // Serial data in pin (SDI / SDA)
  input wire logic sdi_i,
  output logic sdi_o,
  output logic sdi_oe_o,
  // Slave select pin
  input wire logic ss_n_i
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOW = 4'b0010,
    ST_RISE = 4'b0100,
    ST_REL = 4'b1000
  } sps_stop_e;

  initial
  begin
    if (DATA_W < 2 || DATA_W > 15) $error("sps_core: DATA_W out of range");
  end

  localparam logic [3:0] LAST_BIT = 4'(DATA_W - 1);
  localparam logic [4:0] LAST_EDGE = 5'(2 * DATA_W - 1);

  // Register state
  logic [5:0] ctrl_q;
  logic write_collision_flag_q, ovf_q, stop_q, cke_q, bf_q, if_q;
  logic [7:0] ctrl2_q, addr_q;
  logic [DATA_W-1:0] buf_q;
  // Bus state
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  // Shifter state
  logic [DATA_W-1:0] tx_q, rx_q;
  logic [3:0] cnt_q;
  logic [4:0] edge_q;
  logic run_q, lvl_q;
  sps_stop_e st_q;
  // Pins
  logic sck_s, sdi_s, ss_n_s, sck_p_q, sdi_p_q;

  sps_sync2 #(
    .W(3)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({sck_i, sdi_i, ss_n_i}),
    .q_o({sck_s, sdi_s, ss_n_s})
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sck_p_q <= 1'b0;
      sdi_p_q <= 1'b0;
    end
    else
    begin
      sck_p_q <= sck_s;
      sdi_p_q <= sdi_s;
    end
  end

  // Mode decode
  logic en, clock_polarity;
  logic [3:0] mode;
  logic spi_m, spi_s, ss_mode, tw_s, tw_m, spi_on;
  assign en = ctrl_q[sps_pkg::C1_EN];
  assign clock_polarity = ctrl_q[sps_pkg::C1_CKP];
  assign mode = ctrl_q[3:0];
  assign spi_m = en && (mode == sps_pkg::M_SPI_M4 || mode == sps_pkg::M_SPI_M16
                        || mode == sps_pkg::M_SPI_M64 || mode == sps_pkg::M_SPI_MT);
  assign spi_s = en && (mode == sps_pkg::M_SPI_S_SS || mode == sps_pkg::M_SPI_S);
  assign ss_mode = (mode == sps_pkg::M_SPI_S_SS);
  assign tw_s = en && (mode == sps_pkg::M_TW_S7 || mode == sps_pkg::M_TW_S10
                       || mode == sps_pkg::M_TW_S7_SP || mode == sps_pkg::M_TW_S10_SP);
  // Firmware master (1011) leaves the slave and shifter idle; reserved codes match nothing
  assign tw_m = en && (mode == sps_pkg::M_TW_M);
  assign spi_on = spi_s && !(ss_mode && ss_n_s);

  // Bus side
  logic acc, rd_buf, wr_buf, wr_c1, wr_c2, wr_st, wr_ad, wr_ev;
  assign acc = hsel_i && htrans_i[1] && hready_i;
  assign rd_buf = acc && !hwrite_i && haddr_i[7:0] == sps_pkg::REG_BUF;
  assign wr_c1 = wr_pend_q && wr_addr_q == sps_pkg::REG_CTRL1;
  assign wr_c2 = wr_pend_q && wr_addr_q == sps_pkg::REG_CTRL2;
  assign wr_st = wr_pend_q && wr_addr_q == sps_pkg::REG_STAT;
  assign wr_buf = wr_pend_q && wr_addr_q == sps_pkg::REG_BUF;
  assign wr_ad = wr_pend_q && wr_addr_q == sps_pkg::REG_ADDR;
  assign wr_ev = wr_pend_q && wr_addr_q == sps_pkg::REG_EVT;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
      hrdata_o <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= acc && hwrite_i;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (acc)
        wr_addr_q <= haddr_i[7:0];
      if (acc && !hwrite_i)
      begin
        unique case (haddr_i[7:0])
          sps_pkg::REG_CTRL1: hrdata_o <= 32'({write_collision_flag_q, ovf_q, ctrl_q});
          sps_pkg::REG_CTRL2: hrdata_o <= 32'({ctrl2_q[7:3], stop_q, ctrl2_q[1:0]});
          sps_pkg::REG_STAT: hrdata_o <= 32'({cke_q, 5'h00, bf_q});
          sps_pkg::REG_BUF: hrdata_o <= 32'(buf_q);
          sps_pkg::REG_ADDR: hrdata_o <= 32'(addr_q);
          sps_pkg::REG_EVT: hrdata_o <= 32'(if_q);
          default: hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Transfer state
  logic busy, bus_busy, wr_ok, mst_start;
  assign busy = run_q || cnt_q != 4'h0;
  assign bus_busy = st_q != ST_IDLE || !sck_s || !sdi_s;
  assign wr_ok = !busy && !(tw_m && bus_busy);
  assign mst_start = wr_buf && wr_ok && spi_m;

  // Edge generation
  logic tick, sck_rise, sck_fall, lead, trail, samp, chg, byte_done;
  logic [9:0] period;
  assign sck_rise = sck_s && !sck_p_q;
  assign sck_fall = !sck_s && sck_p_q;
  always_comb
  begin
    unique case (mode)
      sps_pkg::M_SPI_M4: period = sps_pkg::HALF_DIV4;
      sps_pkg::M_SPI_M16: period = sps_pkg::HALF_DIV16;
      sps_pkg::M_TW_M: period = {1'b0, addr_q + 8'h01, 1'b0};
      default: period = sps_pkg::HALF_DIV64;
    endcase
  end

  sps_tick #(
    .CNT_W(10)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run_q || st_q != ST_IDLE),
    .period_i(period),
    .tick_o(tick)
  );

  always_comb
  begin
    if (spi_m)
    begin
      lead = tick && run_q && !lvl_q;
      trail = tick && run_q && lvl_q;
    end
    else
    begin
      lead = spi_on && (clock_polarity ? sck_fall : sck_rise);
      trail = spi_on && (clock_polarity ? sck_rise : sck_fall);
    end
  end

  assign samp = tw_s ? sck_rise : (cke_q ? lead : trail);
  assign chg = !tw_s && (cke_q ? trail : (lead && cnt_q != 4'h0));
  assign byte_done = samp && cnt_q == LAST_BIT;

  // Shifter: receive and transmit halves of the shift register
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !en || (spi_s && ss_mode && ss_n_s))
    begin
      cnt_q <= 4'h0;
      rx_q <= '0;
    end
    else if (samp)
    begin
      rx_q <= {rx_q[DATA_W-2:0], sdi_s};
      cnt_q <= byte_done ? 4'h0 : cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_q <= '0;
    else if (wr_buf && wr_ok)
      tx_q <= hwdata_i[DATA_W-1:0];
    else if (chg)
      tx_q <= {tx_q[DATA_W-2:0], 1'b0};
  end

  // Master clock sequencing
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !spi_m)
    begin
      run_q <= 1'b0;
      lvl_q <= 1'b0;
      edge_q <= 5'h00;
    end
    else if (mst_start)
    begin
      run_q <= 1'b1;
      lvl_q <= 1'b0;
      edge_q <= 5'h00;
    end
    else if (run_q && tick)
    begin
      lvl_q <= !lvl_q;
      edge_q <= edge_q + 5'h01;
      if (edge_q == LAST_EDGE)
        run_q <= 1'b0;
    end
  end

  // Buffer and status flags
  logic load, ovf_set, write_collision_flag_set, sp_ev;
  assign load = byte_done && !bf_q;
  assign ovf_set = byte_done && bf_q && (spi_s || tw_s);
  assign write_collision_flag_set = wr_buf && !wr_ok;
  assign sp_ev = en && mode == sps_pkg::M_TW_S10_SP && sck_s && (sdi_s != sdi_p_q);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      buf_q <= '0;
    else if (load)
      buf_q <= {rx_q[DATA_W-2:0], sdi_s};
    else if (wr_buf && wr_ok)
      buf_q <= hwdata_i[DATA_W-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bf_q <= 1'b0;
    else if (load)
      bf_q <= 1'b1;
    else if (rd_buf)
      bf_q <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      if_q <= 1'b0;
    else if (byte_done || sp_ev)
      if_q <= 1'b1;
    else if (wr_ev && hwdata_i[sps_pkg::EV_IF])
      if_q <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= sps_pkg::CTRL1_RST[5:0];
      write_collision_flag_q <= 1'b0;
      ovf_q <= 1'b0;
    end
    else
    begin
      if (wr_c1)
        ctrl_q <= hwdata_i[5:0];
      if (write_collision_flag_set)
        write_collision_flag_q <= 1'b1;
      else if (wr_c1 && !hwdata_i[sps_pkg::C1_WRITE_COLLISION_FLAG])
        write_collision_flag_q <= 1'b0;
      if (ovf_set)
        ovf_q <= 1'b1;
      else if (wr_c1 && !hwdata_i[sps_pkg::C1_OVF])
        ovf_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl2_q <= sps_pkg::CTRL2_RST;
      cke_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      if (wr_c2)
        ctrl2_q <= hwdata_i[7:0];
      if (wr_st)
        cke_q <= hwdata_i[sps_pkg::ST_CKE];
      if (wr_ad)
        addr_q <= hwdata_i[7:0];
    end
  end

  // Stop condition: SDA low with SCL low, release SCL, then release SDA
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !tw_m)
    begin
      st_q <= ST_IDLE;
      stop_q <= 1'b0;
    end
    else
    begin
      if (st_q == ST_REL && tick)
        stop_q <= 1'b0;
      else if (wr_c2 && hwdata_i[sps_pkg::C2_STOP])
        stop_q <= 1'b1;
      unique case (st_q)
        ST_IDLE: if (stop_q) st_q <= ST_LOW;
        ST_LOW: if (tick) st_q <= ST_RISE;
        ST_RISE: if (tick) st_q <= ST_REL;
        ST_REL: if (tick) st_q <= ST_IDLE;
      endcase
    end
  end

  // Pin drivers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sck_o <= 1'b0;
      sck_oe_o <= 1'b0;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
      sdi_o <= 1'b0;
      sdi_oe_o <= 1'b0;
    end
    else
    begin
      sck_o <= spi_m && (clock_polarity ^ lvl_q);
      sck_oe_o <= spi_m || (tw_s && !clock_polarity) || (tw_m && st_q == ST_LOW);
      sdo_o <= tx_q[DATA_W-1];
      sdo_oe_o <= spi_m || spi_on;
      sdi_o <= 1'b0;
      sdi_oe_o <= tw_m && (st_q == ST_LOW || st_q == ST_RISE);
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_master_start;
    mst_start && !cke_q;
  endsequence

  buf_load_a: assert property (load && !rd_buf |=> bf_q && if_q)
    else $error("completed byte did not set full and interrupt flags");
  msb_first_a: assert property (s_master_start |-> ##2 sdo_o == $past(hwdata_i[DATA_W-1], 2))
    else $error("first bit out is not the most significant");
  write_collision_flag_set_a: assert property (wr_buf && busy |=> write_collision_flag_q && !$rose(run_q))
    else $error("write during transfer not flagged");
  read_clear_a: assert property (rd_buf && !load |=> !bf_q)
    else $error("buffer read did not clear full flag");
  ovf_keep_a: assert property (ovf_set && !wr_buf |=> ovf_q && buf_q == $past(buf_q))
    else $error("overflow not flagged or buffer overwritten");
  ovf_slave_a: assert property ($rose(ovf_q) |-> $past(spi_s || tw_s))
    else $error("overflow set outside slave operation");
  idle_level_a: assert property (spi_m && !run_q && $stable(clock_polarity) ##1 spi_m && !run_q
                                 |=> sck_o == $past(clock_polarity) && sck_oe_o)
    else $error("serial clock not at idle level");
  stretch_a: assert property (tw_s && !clock_polarity |=> sck_oe_o && !sck_o)
    else $error("clock not held low in two-wire slave");
  pins_off_a: assert property (!en [*2] |-> !sck_oe_o && !sdo_oe_o && !sdi_oe_o)
    else $error("pins driven while port disabled");
  stop_end_a: assert property ($fell(stop_q) |-> $past(st_q == ST_REL) && !sdi_oe_o)
    else $error("stop request cleared before condition finished");
  if_hold_a: assert property (if_q && !(wr_ev && hwdata_i[sps_pkg::EV_IF]) |=> if_q)
    else $error("interrupt flag dropped without software clear");
endmodule
`default_nettype wire

// file: tb/sps_spi_peer.sv
/*
  Behavioural SPI partner: slave to the port in master mode, master to it in slave mode.
  Assumes the bench resolves the clock line and loads each byte with a start pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module sps_spi_peer #(
  parameter int unsigned HALF = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control from the bench
  input wire logic cpol_i,
  input wire logic master_i,
  input wire logic start_i,
  input wire logic [7:0] tx_i,
  // Serial lines
  input wire logic sck_line_i,
  input wire logic sdo_i,
  output logic sck_o,
  output logic sdi_o,
  // Observed traffic
  output logic [7:0] rx_o,
  output logic [7:0] frames_o
);
  logic [7:0] tx_q;
  logic [3:0] lead_q;
  logic [3:0] trail_q;
  logic [4:0] flips_q;
  logic [7:0] cnt_q;
  logic run_q;
  logic prev_q;
  logic lead;
  logic trail;
  assign lead = (sck_line_i != cpol_i) && (prev_q == cpol_i);
  assign trail = (sck_line_i == cpol_i) && (prev_q != cpol_i);
  // Own clock stands at its idle level outside frames
  assign sck_o = run_q ? (cpol_i ^ flips_q[0]) : cpol_i;
  always_ff @(posedge clk_i)
  begin
    prev_q <= sck_line_i;
    if (rst_i)
    begin
      run_q <= 1'b0;
      frames_o <= 8'h00;
      sdi_o <= 1'b0;
      lead_q <= 4'h8;
      trail_q <= 4'h8;
    end
    else if (start_i)
    begin
      tx_q <= tx_i;
      sdi_o <= tx_i[7];
      lead_q <= 4'h0;
      trail_q <= 4'h0;
      run_q <= master_i;
      cnt_q <= 8'h00;
      flips_q <= 5'h00;
    end
    else
    begin
      if (run_q)
      begin
        cnt_q <= (cnt_q == 8'(HALF - 1)) ? 8'h00 : cnt_q + 8'h01;
        if (cnt_q == 8'(HALF - 1))
        begin
          flips_q <= flips_q + 5'h01;
          run_q <= (flips_q != 5'h0F);
        end
      end
      // Data changes on the leading edge, most significant bit first
      if (lead && lead_q < 4'h8)
      begin
        sdi_o <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
        lead_q <= lead_q + 4'h1;
      end
      if (trail && trail_q < 4'h8)
      begin
        rx_o <= {rx_o[6:0], sdo_i};
        trail_q <= trail_q + 4'h1;
        if (trail_q == 4'h7)
        begin
          frames_o <= frames_o + 8'h01;
          // Released data line shows the inverse of its last level
          sdi_o <= ~sdi_o;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
/*
  Self-checking bench of the serial port: AHB-Lite register access and SPI frames.
  Assumes sps_pkg, sps_core and sps_spi_peer are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready, hresp, sck_o, sck_oe, sdo, sdo_oe, sdi_o, sdi_oe;
  logic ss_n = 1'b0;
  logic tw = 1'b0;
  logic cpol = 1'b0;
  logic pmaster = 1'b0;
  logic pstart = 1'b0;
  logic [7:0] ptx = 8'h00;
  logic peer_sck, peer_sdi, sck_line, sdi_line;
  logic saw_pull = 1'b0;
  logic prev_sck = 1'b0;
  logic [7:0] prx, pframes;
  logic [7:0] rst_regs [5] = '{sps_pkg::REG_CTRL1, sps_pkg::REG_CTRL2, sps_pkg::REG_STAT,
    sps_pkg::REG_EVT, 8'h20};
  int run = 0;
  int gap = 0;
  int cycles = 0;
  int compares = 0;
  int miscompares = 0;
  logic [31:0] r;
  // Open-drain lines float high in two-wire modes
  assign sck_line = sck_oe ? sck_o : (tw ? 1'b1 : peer_sck);
  assign sdi_line = sdi_oe ? sdi_o : (tw ? 1'b1 : peer_sdi);
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  sps_core u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .sck_i(sck_line),
    .sck_o(sck_o), .sck_oe_o(sck_oe), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .sdi_i(sdi_line),
    .sdi_o(sdi_o), .sdi_oe_o(sdi_oe), .ss_n_i(ss_n)
  );
  sps_spi_peer #(.HALF(16)) u_peer (
    .clk_i(clk_i), .rst_i(rst_i), .cpol_i(cpol), .master_i(pmaster), .start_i(pstart),
    .tx_i(ptx), .sck_line_i(sck_line), .sdo_i(sdo), .sck_o(peer_sck), .sdi_o(peer_sdi),
    .rx_o(prx), .frames_o(pframes)
  );
  task automatic complete_run();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Clock half period meter, pull watcher and hang limit
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    prev_sck <= sck_o;
    run <= (sck_o !== prev_sck) ? 1 : run + 1;
    if (sck_o !== prev_sck)
    begin
      gap <= run;
    end
    if (sdi_oe === 1'b1)
    begin
      saw_pull <= 1'b1;
    end
    if (cycles == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_i); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic frame(input logic m, input logic [7:0] t);
    ptx <= t;
    pmaster <= m;
    pstart <= 1'b1;
    @(posedge clk_i);
    pstart <= 1'b0;
  endtask
  task automatic wait_frame(input logic [7:0] n);
    while (pframes !== n) @(posedge clk_i);
    idle(8);
  endtask
  // Disable, reprogram, then enable again
  task automatic cfg(input logic [7:0] c);
    cpol <= c[4];
    wr(sps_pkg::REG_CTRL1, 8'h00);
    wr(sps_pkg::REG_CTRL1, c & 8'hDF);
    wr(sps_pkg::REG_CTRL1, c);
    idle(4);
  endtask
  initial
  begin
    idle(10);
    rst_i <= 1'b0;
    idle(2);
    foreach (rst_regs[i])
    begin
      rd(rst_regs[i]);
      `CHK(r, 32'h0)
    end
    `CHK(sck_oe, 1'b0)
    `CHK(hresp, 1'b0)
    cfg(8'h22);
    `CHK(sck_oe, 1'b1)
    `CHK(sck_o, 1'b0)
    frame(1'b0, 8'hC5);
    wr(sps_pkg::REG_BUF, 8'hA3);
    wr(sps_pkg::REG_BUF, 8'h5A);
    wait_frame(8'd1);
    `CHK(prx, 8'hA3)
    `CHK(gap, 32)
    rd(sps_pkg::REG_STAT);
    `CHK(r[0], 1'b1)
    rd(sps_pkg::REG_EVT);
    `CHK(r[0], 1'b1)
    rd(sps_pkg::REG_CTRL1);
    `CHK(r, 32'hA2)
    rd(sps_pkg::REG_BUF);
    `CHK(r, 32'hC5)
    rd(sps_pkg::REG_STAT);
    `CHK(r[0], 1'b0)
    frame(1'b0, 8'h11);
    wr(sps_pkg::REG_BUF, 8'h0F);
    wait_frame(8'd2);
    frame(1'b0, 8'h22);
    wr(sps_pkg::REG_BUF, 8'hF0);
    wait_frame(8'd3);
    `CHK(prx, 8'hF0)
    rd(sps_pkg::REG_CTRL1);
    `CHK(r, 32'hA2)
    rd(sps_pkg::REG_EVT);
    `CHK(r[0], 1'b1)
    wr(sps_pkg::REG_EVT, 8'h01);
    rd(sps_pkg::REG_EVT);
    `CHK(r[0], 1'b0)
    wr(sps_pkg::REG_CTRL1, 8'h22);
    rd(sps_pkg::REG_CTRL1);
    `CHK(r, 32'h22)
    rd(sps_pkg::REG_BUF);
    cfg(8'h20);
    frame(1'b0, 8'h00);
    wr(sps_pkg::REG_BUF, 8'h69);
    wait_frame(8'd4);
    `CHK(gap, 2)
    `CHK(prx, 8'h69)
    rd(sps_pkg::REG_BUF);
    cfg(8'h32);
    `CHK(sck_o, 1'b1)
    frame(1'b0, 8'h3C);
    wr(sps_pkg::REG_BUF, 8'hC3);
    wait_frame(8'd5);
    `CHK(prx, 8'hC3)
    rd(sps_pkg::REG_BUF);
    `CHK(r, 32'h3C)
    cfg(8'h25);
    `CHK(sck_oe, 1'b0)
    wr(sps_pkg::REG_BUF, 8'h81);
    frame(1'b1, 8'h96);
    wait_frame(8'd6);
    `CHK(prx, 8'h81)
    frame(1'b1, 8'h4B);
    wait_frame(8'd7);
    rd(sps_pkg::REG_CTRL1);
    `CHK(r, 32'h65)
    rd(sps_pkg::REG_BUF);
    `CHK(r, 32'h96)
    wr(sps_pkg::REG_CTRL1, 8'h25);
    rd(sps_pkg::REG_CTRL1);
    `CHK(r, 32'h25)
    tw <= 1'b1;
    for (int i = 9; i < 13; i++)
    begin
      cfg({4'h2, 4'(i)});
      `CHK(sck_oe, 1'b0)
      `CHK(sdo_oe, 1'b0)
    end
    cfg(8'h26);
    `CHK(sck_oe, 1'b1)
    `CHK(sck_o, 1'b0)
    cfg(8'h36);
    `CHK(sck_oe, 1'b0)
    wr(sps_pkg::REG_ADDR, 8'h00);
    cfg(8'h28);
    saw_pull <= 1'b0;
    wr(sps_pkg::REG_CTRL2, 8'h04);
    wr(sps_pkg::REG_BUF, 8'h55);
    repeat (10)
    begin
      rd(sps_pkg::REG_CTRL2);
    end
    `CHK(r, 32'h0)
    `CHK(saw_pull, 1'b1)
    rd(sps_pkg::REG_CTRL1);
    `CHK(r[7], 1'b1)
    complete_run();
  end
endmodule
`default_nettype wire
